// [hdl/gpd_regs.svh]
`ifndef GPD_REGS_SVH
`define GPD_REGS_SVH
// register byte addresses
`define GPD_PTR0_OFS 8'h00
`define GPD_PTR1_OFS 8'h04
`define GPD_POS0_OFS 8'h08
`define GPD_POS1_OFS 8'h0C
`define GPD_PORTA_DATA_OFS 8'h10
`define GPD_PORTA_DIR_OFS 8'h14
`define GPD_CTRL_OFS 8'h18
`define GPD_BEAM_OFS 8'h1C
`define GPD_ANALOG_PIN_OFS 8'h20
// pointer counter word bit positions
`define GPD_PTR_LEFT_BIT 9
`define GPD_PTR_FWD_BIT 8
`define GPD_PTR_RIGHT_BIT 1
`define GPD_PTR_BACK_BIT 0
// port a fire bits
`define GPD_FIRE_LEFT_BIT 7
`define GPD_FIRE_RIGHT_BIT 6
// control register fields
`define GPD_CTRL_PAL_BIT 0
`define GPD_CTRL_PEN_EN_BIT 1
`define GPD_CTRL_PROP_BIT 2
// reset values
`define GPD_PORTA_DIR_RST 8'h00
`define GPD_CTRL_RST 8'h00
// synchroniser idle levels: active-low pins high, comparators, line and field low
`define GPD_PIN_SYNC_RST 17'h10FFC
// timing
`define GPD_DISCHARGE_LINES_525 9'd7
`define GPD_DISCHARGE_LINES_625 9'd8
`endif

// [hdl/gpd_pkg.sv]
package gpd_pkg;
  typedef enum logic [1:0] {
    GPD_IDLE,
    GPD_RD_RESP,
    GPD_WR_RESP
  } gpd_bus_state_type;
  typedef enum logic {
    GPD_DISCHARGE,
    GPD_CHARGE
  } gpd_pot_phase_type;
endpackage : gpd_pkg

// [hdl/gpd_pot_channel.sv]
`timescale 1ns/100ps
// one analog channel: latches the line count at the first threshold crossing
module gpd_pot_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic discharge,
  input wire logic line_tick,
  input wire logic above_thr,
  input wire logic [7:0] line_count,
  output logic [7:0] count
);
  typedef struct packed {
    logic done;
    logic [7:0] count;
  } gpd_chan_state_type;
  gpd_chan_state_type st_r;
  gpd_chan_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (discharge) begin
      st_nxt.done = 1'b0;
      st_nxt.count = 8'h00;
    end else if (!st_r.done) begin
      if (above_thr) begin
        st_nxt.done = 1'b1;
        st_nxt.count = line_count;
      end else if (line_tick) begin
        // tracks the line counter so an uncrossed field keeps its final count
        st_nxt.count = line_count;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.count;

  property p_hold_after_done;
    @(posedge aclk) disable iff (!aresetn)
      (st_r.done && !discharge) |=> (count == $past(count));
  endproperty
  a_hold_after_done: assert property (p_hold_after_done) else $error("latched count moved");

  property p_zero_in_discharge;
    @(posedge aclk) disable iff (!aresetn)
      discharge |=> (count == 8'h00 && !st_r.done);
  endproperty
  a_zero_in_discharge: assert property (p_zero_in_discharge) else $error("count not cleared");
endmodule : gpd_pot_channel

// [hdl/gpd_game_port.sv]
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "gpd_regs.svh"
module gpd_game_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] fwd_low,
  input wire logic [1:0] left_low,
  input wire logic [1:0] right_low,
  input wire logic [1:0] fire_low,
  input wire logic [1:0] horizontal_analog_in,
  input wire logic [1:0] vertical_analog_in,
  input wire logic pen_trigger_low,
  input wire logic line_start,
  input wire logic field_start,
  input wire logic [8:0] beam_v,
  input wire logic [7:0] beam_h,
  output logic [1:0] pot_discharge
);
  // fwd_low[1:0] is forward per port, fwd_low[3:2] back per port

  typedef struct packed {
    gpd_pkg::gpd_bus_state_type bus;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic ar_rdy, aw_rdy, w_rdy, rvld, bvld;
    logic [7:0] porta_dir;
    logic [7:0] porta_out;
    logic [7:0] ctrl;
    logic [8:0] pen_v;
    logic [7:0] pen_h;
    logic pen_prev;
    gpd_pkg::gpd_pot_phase_type phase;
    logic [8:0] lines;
    logic [7:0] line_count;
    logic line_tick;
    logic [1:0] disch;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
  } gpd_state_type;

  gpd_state_type st_r;
  gpd_state_type st_nxt;

  // two-flop synchronisers for every pin input except beam_v and beam_h, which are sampled directly
  logic [16:0] pin_meta_r;
  logic [16:0] pin_sync_r;
  logic [16:0] pin_raw;
  assign pin_raw = {pen_trigger_low, vertical_analog_in, horizontal_analog_in, fire_low,
                    right_low, left_low, fwd_low, line_start, field_start};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_r <= `GPD_PIN_SYNC_RST; // idle levels, so no false pen edge follows reset
      pin_sync_r <= `GPD_PIN_SYNC_RST;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  logic pen_s;
  logic [1:0] vert_s;
  logic [1:0] horz_s;
  logic [1:0] fire_s;
  logic [1:0] right_s;
  logic [1:0] left_s;
  logic [3:0] fwd_s;
  logic line_s;
  logic field_s;
  assign {pen_s, vert_s, horz_s, fire_s, right_s, left_s, fwd_s, line_s, field_s} = pin_sync_r;

  logic line_prev_r;
  logic field_prev_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_prev_r <= 1'b0;
      field_prev_r <= 1'b0;
    end else begin
      line_prev_r <= line_s;
      field_prev_r <= field_s;
    end
  end
  logic line_rise;
  logic field_rise;
  assign line_rise = line_s && !line_prev_r;
  assign field_rise = field_s && !field_prev_r;

  logic [7:0] pos0_h;
  logic [7:0] pos0_v;
  logic [7:0] pos1_h;
  logic [7:0] pos1_v;
  logic [3:0] above;
  // the comparator is outside; its digital result arrives on the analog pins
  assign above = {vert_s[1], horz_s[1], vert_s[0], horz_s[0]};

  gpd_pot_channel u_ch0h (.aclk(aclk), .aresetn(aresetn), .discharge(st_r.disch[0]),
    .line_tick(st_r.line_tick), .above_thr(above[0]), .line_count(st_r.line_count), .count(pos0_h));
  gpd_pot_channel u_ch0v (.aclk(aclk), .aresetn(aresetn), .discharge(st_r.disch[0]),
    .line_tick(st_r.line_tick), .above_thr(above[1]), .line_count(st_r.line_count), .count(pos0_v));
  gpd_pot_channel u_ch1h (.aclk(aclk), .aresetn(aresetn), .discharge(st_r.disch[1]),
    .line_tick(st_r.line_tick), .above_thr(above[2]), .line_count(st_r.line_count), .count(pos1_h));
  gpd_pot_channel u_ch1v (.aclk(aclk), .aresetn(aresetn), .discharge(st_r.disch[1]),
    .line_tick(st_r.line_tick), .above_thr(above[3]), .line_count(st_r.line_count), .count(pos1_v));

  function automatic logic [15:0] gpd_joy_word(input logic fwd_n, input logic back_n,
                                                input logic left_n, input logic right_n,
                                                input logic prop);
    logic l;
    logic r;
    logic f;
    logic b;
    l = !left_n;
    r = !right_n;
    f = prop ? 1'b0 : !fwd_n;
    b = prop ? 1'b0 : !back_n;
    gpd_joy_word = 16'h0000; // left and forward code in the high byte, right and back code in the low
    gpd_joy_word[`GPD_PTR_LEFT_BIT] = l;
    gpd_joy_word[`GPD_PTR_RIGHT_BIT] = r;
    gpd_joy_word[`GPD_PTR_FWD_BIT] = l ^ f;
    gpd_joy_word[`GPD_PTR_BACK_BIT] = r ^ b;
  endfunction : gpd_joy_word

  logic [7:0] fire_bits;
  always_comb begin
    fire_bits = 8'h00;
    fire_bits[`GPD_FIRE_LEFT_BIT] = fire_s[0];
    fire_bits[`GPD_FIRE_RIGHT_BIT] = fire_s[1];
  end

  logic [31:0] rd_val;
  logic rd_ok;
  logic [7:0] pa_read;
  // pins set as output read back the driven latch; inputs read fire levels
  assign pa_read = (st_r.porta_dir & st_r.porta_out) | (~st_r.porta_dir & fire_bits);

  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h00000000;
    if (s_axi_araddr == `GPD_PTR0_OFS) begin
      rd_val = {16'h0000, st_r.ptr0};
    end else if (s_axi_araddr == `GPD_PTR1_OFS) begin
      rd_val = {16'h0000, st_r.ptr1};
    end else if (s_axi_araddr == `GPD_POS0_OFS) begin
      rd_val = {16'h0000, pos0_v, pos0_h};
    end else if (s_axi_araddr == `GPD_POS1_OFS) begin
      rd_val = {16'h0000, pos1_v, pos1_h};
    end else if (s_axi_araddr == `GPD_PORTA_DATA_OFS) begin
      rd_val = {24'h000000, pa_read};
    end else if (s_axi_araddr == `GPD_PORTA_DIR_OFS) begin
      rd_val = {24'h000000, st_r.porta_dir};
    end else if (s_axi_araddr == `GPD_CTRL_OFS) begin
      rd_val = {24'h000000, st_r.ctrl};
    end else if (s_axi_araddr == `GPD_BEAM_OFS) begin
      // pen position only; there is deliberately no trigger flag
      rd_val = {15'h0000, st_r.pen_v, st_r.pen_h};
    end else if (s_axi_araddr == `GPD_ANALOG_PIN_OFS) begin
      rd_val = {28'h0000000, vert_s[1], horz_s[1], vert_s[0], horz_s[0]};
    end else begin
      rd_ok = 1'b0;
    end
  end

  logic pal;
  logic prop;
  assign pal = st_r.ctrl[`GPD_CTRL_PAL_BIT];
  assign prop = st_r.ctrl[`GPD_CTRL_PROP_BIT];

  always_comb begin
    st_nxt = st_r;
    st_nxt.line_tick = 1'b0;
    // joystick words are recomputed every cycle so reads are never torn
    st_nxt.ptr0 = gpd_joy_word(fwd_s[0], fwd_s[2], left_s[0], right_s[0], prop);
    st_nxt.ptr1 = gpd_joy_word(fwd_s[1], fwd_s[3], left_s[1], right_s[1], prop);
    st_nxt.pen_prev = pen_s;
    if (st_r.ctrl[`GPD_CTRL_PEN_EN_BIT] && st_r.pen_prev && !pen_s) begin
      st_nxt.pen_v = beam_v;
      st_nxt.pen_h = beam_h;
    end
    if (field_rise) begin
      st_nxt.phase = gpd_pkg::GPD_DISCHARGE;
      st_nxt.lines = 9'd0;
      st_nxt.line_count = 8'h00;
      st_nxt.disch = 2'b11;
    end else if (line_rise) begin
      case (st_r.phase)
        gpd_pkg::GPD_DISCHARGE: begin
          st_nxt.lines = st_r.lines + 9'd1;
          if (st_r.lines + 9'd1 >= (pal ? `GPD_DISCHARGE_LINES_625 : `GPD_DISCHARGE_LINES_525)) begin
            st_nxt.phase = gpd_pkg::GPD_CHARGE;
            st_nxt.disch = 2'b00;
          end
        end
        gpd_pkg::GPD_CHARGE: begin
          if (st_r.line_count != 8'hFF) begin
            st_nxt.line_count = st_r.line_count + 8'h01;
            st_nxt.line_tick = 1'b1;
          end
        end
        default: begin
          st_nxt.phase = gpd_pkg::GPD_DISCHARGE;
        end
      endcase
    end
    case (st_r.bus)
      gpd_pkg::GPD_IDLE: begin
        if (s_axi_awvalid && !st_r.aw_got) begin
          st_nxt.aw_got = 1'b1;
          st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_got) begin
          st_nxt.w_got = 1'b1;
          st_nxt.wdata = s_axi_wdata;
          st_nxt.wstrb = s_axi_wstrb;
        end
        if (s_axi_arvalid) begin
          st_nxt.rdata = rd_val;
          st_nxt.resp = rd_ok ? 2'b00 : 2'b10;
          st_nxt.bus = gpd_pkg::GPD_RD_RESP;
        end else begin
          if (st_r.aw_got && st_r.w_got) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.resp = 2'b00;
            st_nxt.bus = gpd_pkg::GPD_WR_RESP;
            if (st_r.awaddr == `GPD_PORTA_DIR_OFS) begin
              if (st_r.wstrb[0]) st_nxt.porta_dir = st_r.wdata[7:0];
            end else if (st_r.awaddr == `GPD_PORTA_DATA_OFS) begin
              if (st_r.wstrb[0]) st_nxt.porta_out = st_r.wdata[7:0];
            end else if (st_r.awaddr == `GPD_CTRL_OFS) begin
              if (st_r.wstrb[0]) st_nxt.ctrl = {5'h00, st_r.wdata[2:0]};
            end else if (st_r.awaddr != `GPD_PTR0_OFS && st_r.awaddr != `GPD_PTR1_OFS &&
                         st_r.awaddr != `GPD_POS0_OFS && st_r.awaddr != `GPD_POS1_OFS &&
                         st_r.awaddr != `GPD_BEAM_OFS && st_r.awaddr != `GPD_ANALOG_PIN_OFS) begin
              st_nxt.resp = 2'b10; // read-only offsets answer okay and ignore the data
            end
          end
        end
      end
      gpd_pkg::GPD_RD_RESP: begin
        if (s_axi_rready) st_nxt.bus = gpd_pkg::GPD_IDLE;
      end
      gpd_pkg::GPD_WR_RESP: begin
        if (s_axi_bready) st_nxt.bus = gpd_pkg::GPD_IDLE;
      end
      default: begin
        st_nxt.bus = gpd_pkg::GPD_IDLE;
      end
    endcase
    st_nxt.ar_rdy = (st_nxt.bus == gpd_pkg::GPD_IDLE);
    st_nxt.aw_rdy = st_nxt.ar_rdy && !st_nxt.aw_got;
    st_nxt.w_rdy = st_nxt.ar_rdy && !st_nxt.w_got;
    st_nxt.rvld = (st_nxt.bus == gpd_pkg::GPD_RD_RESP);
    st_nxt.bvld = (st_nxt.bus == gpd_pkg::GPD_WR_RESP);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.porta_dir <= `GPD_PORTA_DIR_RST;
      st_r.ctrl <= `GPD_CTRL_RST;
      st_r.pen_prev <= 1'b1;
      st_r.disch <= 2'b11;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_arready = st_r.ar_rdy;
  assign s_axi_awready = st_r.aw_rdy;
  assign s_axi_wready = st_r.w_rdy;
  assign s_axi_rvalid = st_r.rvld;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.resp;
  assign s_axi_bvalid = st_r.bvld;
  assign s_axi_bresp = st_r.resp;
  assign pot_discharge = st_r.disch;

  property p_ptr_left;
    @(posedge aclk) disable iff (!aresetn)
      ##1 (st_r.ptr0[`GPD_PTR_LEFT_BIT] == !$past(left_s[0]));
  endproperty
  a_ptr_left: assert property (p_ptr_left) else $error("left bit wrong");

  property p_ptr_fwd;
    @(posedge aclk) disable iff (!aresetn)
      ##1 ((st_r.ptr0[9] ^ st_r.ptr0[8]) == ($past(!fwd_s[0]) && !$past(prop)));
  endproperty
  a_ptr_fwd: assert property (p_ptr_fwd) else $error("forward code wrong");

  property p_ptr_back;
    @(posedge aclk) disable iff (!aresetn)
      ##1 ((st_r.ptr1[1] ^ st_r.ptr1[0]) == ($past(!fwd_s[3]) && !$past(prop)));
  endproperty
  a_ptr_back: assert property (p_ptr_back) else $error("back code wrong");

  property p_fire_input;
    @(posedge aclk) disable iff (!aresetn)
      !st_r.porta_dir[`GPD_FIRE_LEFT_BIT] |-> (pa_read[`GPD_FIRE_LEFT_BIT] == fire_s[0]);
  endproperty
  a_fire_input: assert property (p_fire_input) else $error("fire level not shown");

  property p_discharge_len;
    @(posedge aclk) disable iff (!aresetn)
      (st_r.phase == gpd_pkg::GPD_CHARGE && $past(st_r.phase) == gpd_pkg::GPD_DISCHARGE)
        |-> ($past(st_r.lines) + 9'd1 == (pal ? 9'd8 : 9'd7));
  endproperty
  a_discharge_len: assert property (p_discharge_len) else $error("discharge length wrong");

  property p_count_zero;
    @(posedge aclk) disable iff (!aresetn)
      (st_r.phase == gpd_pkg::GPD_DISCHARGE) |-> (st_r.line_count == 8'h00 && st_r.disch == 2'b11);
  endproperty
  a_count_zero: assert property (p_count_zero) else $error("counter not held");

  property p_line_step;
    @(posedge aclk) disable iff (!aresetn)
      (line_rise && !field_rise && st_r.phase == gpd_pkg::GPD_CHARGE && st_r.line_count != 8'hFF)
        |=> (st_r.line_count == $past(st_r.line_count) + 8'h01);
  endproperty
  a_line_step: assert property (p_line_step) else $error("line count not advancing");

  property p_pen_latch;
    @(posedge aclk) disable iff (!aresetn)
      (st_r.ctrl[`GPD_CTRL_PEN_EN_BIT] && st_r.pen_prev && !pen_s) |=> (st_r.pen_h == $past(beam_h));
  endproperty
  a_pen_latch: assert property (p_pen_latch) else $error("pen not latched");
endmodule : gpd_game_port

// [tb/gpd_far_side.sv]
`timescale 1ns/100ps
// video timing, pot charging and pen pulses as seen from the connector side
module gpd_far_side #(
  parameter int LINE_CYC = 16,
  parameter int FIELD_LINES = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] pot_discharge,
  input wire logic [31:0] res,
  input wire logic pen_arm,
  input wire logic [7:0] pen_line,
  output logic [1:0] horizontal_analog_in,
  output logic [1:0] vertical_analog_in,
  output logic pen_trigger_low,
  output logic line_start,
  output logic field_start,
  output logic [8:0] beam_v,
  output logic [7:0] beam_h
);
  int phase;
  int line;
  logic [7:0] chg [2];
  logic [3:0] cmp;
  assign line_start = (phase == 0);
  assign field_start = (line == 0) && (phase == LINE_CYC / 4);
  assign beam_v = {1'h1, line[7:0]};
  assign beam_h = line[7:0] + 8'h30;
  // pulse sits mid-line so the beam word is stable around it
  assign pen_trigger_low = ~(pen_arm && line[7:0] == pen_line && phase >= LINE_CYC / 2 && phase < LINE_CYC / 2 + 4);
  assign {vertical_analog_in[1], horizontal_analog_in[1], vertical_analog_in[0], horizontal_analog_in[0]} = cmp;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 0;
      line <= 0;
    end else if (phase == LINE_CYC - 1) begin
      phase <= 0;
      line <= (line == FIELD_LINES - 1) ? 0 : line + 1;
    end else begin
      phase <= phase + 1;
    end
    for (int p = 0; p < 2; p++) begin
      if (!aresetn || pot_discharge[p]) chg[p] <= 8'h00;
      else if (line_start && chg[p] != 8'hFF) chg[p] <= chg[p] + 8'h01;
    end
    // comparator moves mid-line only, away from the count step
    for (int c = 0; c < 4; c++) begin
      if (!aresetn || pot_discharge[c / 2]) cmp[c] <= 1'h0;
      else if (phase == LINE_CYC / 2) cmp[c] <= (chg[c / 2] >= res[c * 8 +: 8]);
    end
  end
endmodule : gpd_far_side

// [tb/tb_game_port_input_decoder.sv]
`timescale 1ns/100ps
`include "gpd_regs.svh"
module tb_game_port_input_decoder;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pen_low, line_start, field_start, pen_arm, dis_prev;
  logic [7:0] awaddr, araddr, beam_h, pen_line;
  logic [31:0] wdata, rdata, res, d;
  logic [1:0] bresp, rresp, rsp, left_low, right_low, fire_low, h_in, v_in, pot_discharge;
  logic [3:0] fwd_low;
  logic [8:0] beam_v;
  int miscompares, checks, cyc, dis_cnt, dis_last;

  gpd_game_port uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fwd_low(fwd_low),
    .left_low(left_low), .right_low(right_low), .fire_low(fire_low), .horizontal_analog_in(h_in),
    .vertical_analog_in(v_in), .pen_trigger_low(pen_low), .line_start(line_start),
    .field_start(field_start), .beam_v(beam_v), .beam_h(beam_h), .pot_discharge(pot_discharge));

  gpd_far_side far (.aclk(aclk), .aresetn(aresetn), .pot_discharge(pot_discharge), .res(res),
    .pen_arm(pen_arm), .pen_line(pen_line), .horizontal_analog_in(h_in), .vertical_analog_in(v_in),
    .pen_trigger_low(pen_low), .line_start(line_start), .field_start(field_start), .beam_v(beam_v),
    .beam_h(beam_h));

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  task automatic finish_test;
    $display("compares %0d mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      finish_test();
    end
  end

  // lines seen while port 0 is discharged, kept once it lets go
  always @(posedge aclk) begin
    dis_prev <= pot_discharge[0];
    if (!pot_discharge[0]) dis_cnt <= 0;
    else if (line_start) dis_cnt <= dis_cnt + 1;
    if (dis_prev && !pot_discharge[0]) dis_last <= dis_cnt;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
    logic aw_ok, w_ok;
    int n;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (!aw_ok && awready) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
      if (bvalid) begin
        check({30'h0, bresp}, {30'h0, er}, "write response");
        bready <= 1'h0;
        n = 1000;
      end
    end
    if (n < 1000) check(32'h0, 32'h1, "write answer missing");
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] r);
    int n;
    n = 0;
    dt = 32'h0;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        dt = rdata;
        r = rresp;
        rready <= 1'h0;
        n = 1000;
      end
    end
    if (n < 1000) check(32'h0, 32'h1, "read answer missing");
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    check({30'h0, r}, {30'h0, er}, "read response");
    check(v & m, exp, "read data");
  endtask : rd_chk

  task automatic wait_dis(input logic [1:0] v);
    int n;
    n = 0;
    while (pot_discharge !== v && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 3000) check(32'h0, 32'h1, "discharge wait");
  endtask : wait_dis

  task automatic wait_pen;
    int n;
    n = 0;
    while (pen_low !== 1'h0 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    repeat (8) @(posedge aclk);
  endtask : wait_pen

  // r holds charge lines {v1, h1, v0, h0}
  task automatic field_run(input logic [31:0] r, input int lines);
    res <= r;
    wait_dis(2'h0);
    wait_dis(2'h3);
    rd_chk(`GPD_POS0_OFS, 32'hFFFF, 32'h0, 2'h0);
    rd_chk(`GPD_ANALOG_PIN_OFS, 32'hF, 32'h0, 2'h0);
    wait_dis(2'h0);
    @(posedge aclk);
    check(dis_last, lines, "discharge lines");
    repeat (45 * 16) @(posedge aclk);
    rd_chk(`GPD_POS0_OFS, 32'hFFFFFFFF, {16'h0, r[15:0]}, 2'h0);
    rd_chk(`GPD_POS1_OFS, 32'hFFFFFFFF, {16'h0, r[31:16]}, 2'h0);
    rd_chk(`GPD_ANALOG_PIN_OFS, 32'hF, 32'hF, 2'h0);
  endtask : field_run

  function automatic logic [31:0] ptr_exp(input logic [3:0] k, input logic prop);
    logic f, b;
    f = k[3] & ~prop;
    b = k[2] & ~prop;
    ptr_exp = {22'h0, k[1], k[1] ^ f, 6'h0, k[0], k[0] ^ b};
  endfunction : ptr_exp

  initial begin
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, pen_arm} = 6'h0;
    {awaddr, araddr, pen_line} = 24'h0;
    wdata = 32'h0;
    res = 32'h0;
    fwd_low = 4'hF;
    {left_low, right_low, fire_low} = 6'h3F;
    cyc = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd_chk(`GPD_PORTA_DIR_OFS, 32'hFF, 32'h0, 2'h0);
    rd_chk(`GPD_CTRL_OFS, 32'hFF, 32'h0, 2'h0);
    rd_chk(8'h24, 32'hFFFFFFFF, 32'h0, 2'h2);
    wr(8'h24, 32'h1, 2'h2);
    wr(`GPD_PORTA_DIR_OFS, 32'hC5, 2'h0);
    wr(`GPD_PORTA_DATA_OFS, 32'h40, 2'h0);
    rd_chk(`GPD_PORTA_DATA_OFS, 32'hC0, 32'h40, 2'h0);
    rd(`GPD_PORTA_DIR_OFS, d, rsp);
    wr(`GPD_PORTA_DIR_OFS, d & 32'hFFFFFF3F, 2'h0);
    rd_chk(`GPD_PORTA_DIR_OFS, 32'hFF, 32'h05, 2'h0);
    for (int m = 0; m < 32; m++) begin
      if (m == 16) wr(`GPD_CTRL_OFS, 32'h4, 2'h0);
      fwd_low <= {m[2], ~m[2], m[3], ~m[3]};
      left_low <= {m[1], ~m[1]};
      right_low <= {m[0], ~m[0]};
      fire_low <= m[1:0];
      repeat (4) @(posedge aclk);
      rd_chk(`GPD_PTR0_OFS, 32'hFFFFFFFF, ptr_exp(m[3:0], m[4]), 2'h0);
      rd_chk(`GPD_PTR1_OFS, 32'hFFFFFFFF, ptr_exp(~m[3:0], m[4]), 2'h0);
      rd_chk(`GPD_PORTA_DATA_OFS, 32'hC0, {24'h0, m[0], m[1], 6'h0}, 2'h0);
    end
    wr(`GPD_PTR0_OFS, 32'hFFFF, 2'h0);
    rd_chk(`GPD_PTR0_OFS, 32'hFFFFFFFF, ptr_exp(4'hF, 1'h1), 2'h0);
    wr(`GPD_CTRL_OFS, 32'h0, 2'h0);
    field_run(32'h21140500, 7);
    wr(`GPD_CTRL_OFS, 32'h1, 2'h0);
    field_run(32'h01280C07, 8);
    wr(`GPD_CTRL_OFS, 32'h2, 2'h0);
    pen_line <= 8'h14;
    pen_arm <= 1'h1;
    wait_pen();
    rd_chk(`GPD_BEAM_OFS, 32'h1FFFF, 32'h11444, 2'h0);
    wr(`GPD_CTRL_OFS, 32'h0, 2'h0);
    pen_line <= 8'h1E;
    wait_pen();
    rd_chk(`GPD_BEAM_OFS, 32'h1FFFF, 32'h11444, 2'h0);
    finish_test();
  end
endmodule : tb_game_port_input_decoder
